// [verilog/twesp_pkg.sv]
/*
 * constants and types shared by the two-wire serial eeprom slave
 * assumes a 200 MHz system clock that oversamples the bus pins
 */
package twesp_pkg;

  // ******************************************************************
  // addressing
  // ******************************************************************
  localparam logic [3:0] DEV_SEL = 4'hA;
  localparam int unsigned ADDR_W_LARGE = 13;
  localparam int unsigned ADDR_W_SMALL = 12;
  localparam int unsigned PAGE_W = 5;
  localparam int unsigned PAGE_BYTES = 32;
  localparam logic [1:0] PROT_QUAD = 2'h3;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // ******************************************************************
  // timing
  // ******************************************************************
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned PROG_TIME_MS = 10;
  localparam int unsigned PROG_TIME_LOW_MS = 20;
  // worst-case times counted in system clocks
  localparam int unsigned PROG_CYCLES_STD = PROG_TIME_MS * 1000 * CLK_MHZ;
  localparam int unsigned PROG_CYCLES_LOW = PROG_TIME_LOW_MS * 1000 * CLK_MHZ;

  // ******************************************************************
  // types
  // ******************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX = 3'h1,
    ST_ACK = 3'h2,
    ST_TX = 3'h3,
    ST_MACK = 3'h4,
    ST_PROG = 3'h5
  } twesp_state_t;

  typedef enum logic [1:0] {
    PH_DEV = 2'h0,
    PH_AHI = 2'h1,
    PH_ALO = 2'h2,
    PH_DATA = 2'h3
  } twesp_phase_t;

  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
  } twesp_ev_t;

endpackage : twesp_pkg

// [verilog/twesp_top.sv]
/*
 * two-wire serial eeprom slave: device addressing, word addressing,
 * page write with self-timed programming, current/random/sequential read
 * assumes scl, sda and the straps are asynchronous pins, sda open drain
 * with an external pull-up, and the strap pins pulled low when floating
 */
// Operation
// [RULE1] device address high nibble must hold the fixed one-zero selector pattern
// [RULE2] next three address bits must equal the three chip-select strap levels
// [RULE3] a floating chip-select strap counts as logic zero
// [RULE4] address lsb one means read, zero means write
// [RULE5] match gets an acknowledge; mismatch returns to standby, ignores the rest
// [RULE6] write-guard high blocks changes to the upper array quarter
// [RULE7] write carries two word-address bytes then data, each acknowledged
// [RULE8] master ends a write with stop to launch programming
// [RULE9] during programming all bus inputs ignored, no response given
// [RULE10] page write takes up to 31 more bytes, each acknowledged
// [RULE11] only low five address bits advance during writes
// [RULE12] more than 32 bytes wrap and overwrite earlier bytes of the page
// [RULE13] polling start and address acknowledged only after programming ends
// [RULE14] address counter holds last accessed location plus one between transfers
// [RULE15] read address wraps from last array byte to first
// [RULE16] read-direction address acknowledged, then byte at counter shifted out
// [RULE17] random read: dummy write of address, repeated start, read address
// [RULE18] each master acknowledge advances the address and sends the next byte
// [RULE19] master ends a read with no acknowledge then stop
// [RULE20] word-address bits above the array size are ignored
// [RULE21] start is sda falling with scl high, stop sda rising with scl high
// [RULE22] receiver drives sda low in the ninth clock as acknowledge
// [RULE23] programming lasts at most 10 ms, 20 ms for the low-supply variant
// [RULE24] sda sampled at scl rise, own sda changed after scl falls
// [RULE25] protected writes still acknowledged but leave data unchanged
`timescale 1ns/100ps

module twesp_top #(
  parameter int unsigned ADDR_W = twesp_pkg::ADDR_W_LARGE,
  parameter bit LOW_SUPPLY = 1'b0,
  parameter int unsigned PROG_CYCLES = LOW_SUPPLY ? twesp_pkg::PROG_CYCLES_LOW :
                                                    twesp_pkg::PROG_CYCLES_STD
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  input wire logic CHIP_SELECT_STRAP_MSB_I,
  input wire logic CHIP_SELECT_STRAP_MID_I,
  input wire logic CHIP_SELECT_STRAP_LSB_I,
  input wire logic WRITE_GUARD_I
);

  localparam int unsigned DEPTH = 1 << ADDR_W;
  localparam int unsigned PW = twesp_pkg::PAGE_W;
  localparam logic [31:0] PROG_LAST = 32'(PROG_CYCLES - 1);

  // ******************************************************************
  // reset release and pin synchronisers
  // ******************************************************************
  logic rst_s1_q;
  logic rst_n;
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  logic [5:0] pin_s1_q;
  logic [5:0] pin_s2_q;
  logic scl_s3_q;
  logic sda_s3_q;
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 6'h03;
      pin_s2_q <= 6'h03;
      scl_s3_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end else begin
      pin_s1_q <= {WRITE_GUARD_I, CHIP_SELECT_STRAP_MSB_I, CHIP_SELECT_STRAP_MID_I,
                   CHIP_SELECT_STRAP_LSB_I, SCL_I, SDA_I};
      pin_s2_q <= pin_s1_q;
      scl_s3_q <= pin_s2_q[1];
      sda_s3_q <= pin_s2_q[0];
    end
  end

  // floating straps reach us as low through the pad pull-down
  wire [2:0] strap = pin_s2_q[4:2]; // [RULE3]
  wire guard = pin_s2_q[5];
  wire scl_s = pin_s2_q[1];

  // ******************************************************************
  // bus events
  // ******************************************************************
  twesp_pkg::twesp_ev_t ev;
  assign ev.sda = pin_s2_q[0];
  assign ev.scl_rise = scl_s & ~scl_s3_q;
  assign ev.scl_fall = ~scl_s & scl_s3_q;
  assign ev.start = scl_s & scl_s3_q & ~pin_s2_q[0] & sda_s3_q; // [RULE21]
  assign ev.stop = scl_s & scl_s3_q & pin_s2_q[0] & ~sda_s3_q; // [RULE21]

  function automatic logic is_prot(input logic g, input logic [ADDR_W-1:0] a);
    is_prot = g && (a[ADDR_W-1 -: 2] == twesp_pkg::PROT_QUAD);
  endfunction : is_prot

  // ******************************************************************
  // state
  // ******************************************************************
  twesp_pkg::twesp_state_t st_q, st_d;
  twesp_pkg::twesp_phase_t ph_q, ph_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d;
  logic oe_q, oe_d;
  logic rw_q, rw_d;
  logic mack_q, mack_d;
  logic pg_any_q, pg_any_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [31:0] prog_q, prog_d;
  logic [ADDR_W-PW-1:0] row_q;
  logic [twesp_pkg::PAGE_BYTES-1:0] mask_q;
  logic [7:0] pg_data_q [twesp_pkg::PAGE_BYTES];
  logic [7:0] mem_q [DEPTH];
  logic pg_clr;
  logic pg_wr;
  logic tx_load;

  wire byte_done = ev.scl_fall && (cnt_q == twesp_pkg::BYTE_BITS);
  wire dev_match = (shift_q[7:4] == twesp_pkg::DEV_SEL) && // [RULE1]
                   (shift_q[3:1] == strap); // [RULE2]
  wire prog_done = (st_q == twesp_pkg::ST_PROG) && (prog_q == PROG_LAST);
  wire [7:0] rd_byte = mem_q[addr_q];
  wire [ADDR_W-1:0] addr_inc = ADDR_W'(addr_q + 1'b1); // [RULE15]
  wire [ADDR_W-1:0] addr_pg_inc = {addr_q[ADDR_W-1:PW],
                                   PW'(addr_q[PW-1:0] + 1'b1)}; // [RULE11]
  wire wr_prot = is_prot(guard, addr_q);

  assign SDA_O = 1'b0;
  assign SDA_OE_O = oe_q;

  // ******************************************************************
  // protocol sequencer
  // ******************************************************************
  always_comb begin
    st_d = st_q;
    ph_d = ph_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    oe_d = oe_q;
    rw_d = rw_q;
    mack_d = mack_q;
    pg_any_d = pg_any_q;
    addr_d = addr_q;
    prog_d = prog_q;
    pg_clr = 1'b0;
    pg_wr = 1'b0;
    tx_load = 1'b0;
    if (st_q == twesp_pkg::ST_PROG) begin
      // bus deaf until the cycle ends; a poll in flight is not answered
      prog_d = 32'(prog_q + 32'h1); // [RULE9] [RULE23]
      if (prog_done) begin
        st_d = twesp_pkg::ST_IDLE; // [RULE13]
      end
    end else if (ev.stop) begin
      oe_d = 1'b0;
      prog_d = 32'h0;
      pg_any_d = 1'b0;
      st_d = (!rw_q && pg_any_q) ? twesp_pkg::ST_PROG : twesp_pkg::ST_IDLE; // [RULE8]
    end else if (ev.start) begin
      st_d = twesp_pkg::ST_RX;
      ph_d = twesp_pkg::PH_DEV;
      cnt_d = 4'h0;
      oe_d = 1'b0;
    end else begin
      unique case (st_q)
        twesp_pkg::ST_IDLE: begin
        end
        twesp_pkg::ST_RX: begin
          if (ev.scl_rise) begin
            shift_d = {shift_q[6:0], ev.sda}; // [RULE24]
            cnt_d = 4'(cnt_q + 4'h1);
          end else if (byte_done) begin
            oe_d = 1'b1; // [RULE22]
            st_d = twesp_pkg::ST_ACK;
            unique case (ph_q)
              twesp_pkg::PH_DEV: begin
                if (dev_match) begin
                  rw_d = shift_q[0]; // [RULE4]
                  pg_clr = ~shift_q[0];
                  pg_any_d = 1'b0;
                end else begin
                  oe_d = 1'b0; // [RULE5]
                  st_d = twesp_pkg::ST_IDLE;
                end
              end
              twesp_pkg::PH_AHI: begin
                addr_d[ADDR_W-1:8] = shift_q[ADDR_W-9:0]; // [RULE20] [RULE7]
              end
              twesp_pkg::PH_ALO: begin
                addr_d[7:0] = shift_q; // [RULE7] [RULE17]
              end
              twesp_pkg::PH_DATA: begin
                pg_wr = 1'b1; // [RULE10] [RULE25]
                pg_any_d = 1'b1;
                addr_d = addr_pg_inc; // [RULE11] [RULE14]
              end
            endcase
          end
        end
        twesp_pkg::ST_ACK: begin
          if (ev.scl_fall) begin
            cnt_d = 4'h0;
            if (ph_q == twesp_pkg::PH_DEV && rw_q) begin
              tx_load = 1'b1; // [RULE16]
            end else begin
              oe_d = 1'b0;
              st_d = twesp_pkg::ST_RX;
              ph_d = (ph_q == twesp_pkg::PH_DATA) ? twesp_pkg::PH_DATA :
                     twesp_pkg::twesp_phase_t'(2'(ph_q + 2'h1));
            end
          end
        end
        twesp_pkg::ST_TX: begin
          if (ev.scl_rise) begin
            cnt_d = 4'(cnt_q + 4'h1);
          end else if (byte_done) begin
            oe_d = 1'b0;
            st_d = twesp_pkg::ST_MACK;
          end else if (ev.scl_fall) begin
            shift_d = {shift_q[6:0], 1'b0};
            oe_d = ~shift_q[6]; // [RULE24]
          end
        end
        twesp_pkg::ST_MACK: begin
          if (ev.scl_rise) begin
            mack_d = ~ev.sda;
          end else if (ev.scl_fall) begin
            cnt_d = 4'h0;
            if (mack_q) begin
              tx_load = 1'b1; // [RULE18]
            end else begin
              st_d = twesp_pkg::ST_IDLE; // [RULE19]
            end
          end
        end
        default: begin
          st_d = twesp_pkg::ST_IDLE;
        end
      endcase
      if (tx_load) begin
        st_d = twesp_pkg::ST_TX;
        shift_d = rd_byte;
        oe_d = ~rd_byte[7];
        addr_d = addr_inc; // [RULE14] [RULE15]
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= twesp_pkg::ST_IDLE;
      ph_q <= twesp_pkg::PH_DEV;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      oe_q <= 1'b0;
      rw_q <= 1'b1;
      mack_q <= 1'b0;
      pg_any_q <= 1'b0;
      addr_q <= '0;
      prog_q <= 32'h0;
    end else begin
      st_q <= st_d;
      ph_q <= ph_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      oe_q <= oe_d;
      rw_q <= rw_d;
      mack_q <= mack_d;
      pg_any_q <= pg_any_d;
      addr_q <= addr_d;
      prog_q <= prog_d;
    end
  end

  // ******************************************************************
  // page buffer and array
  // ******************************************************************
  // bytes collect in a page buffer so a wrapped page simply overwrites
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= '0;
      row_q <= '0;
    end else if (pg_clr) begin
      mask_q <= '0;
    end else if (pg_wr) begin
      mask_q[addr_q[PW-1:0]] <= ~wr_prot; // [RULE6] [RULE25]
      row_q <= addr_q[ADDR_W-1:PW];
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (pg_wr) begin
      pg_data_q[addr_q[PW-1:0]] <= shift_q; // [RULE12]
    end
  end

  // array contents survive reset, as the cells would
  always_ff @(posedge CLK_SYS_I) begin
    for (int i = 0; i < twesp_pkg::PAGE_BYTES; i++) begin
      if (prog_done && mask_q[i]) begin
        mem_q[{row_q, PW'(i)}] <= pg_data_q[i];
      end
    end
  end

  // ******************************************************************
  // checks
  // ******************************************************************
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!rst_n);

  a_busy_silent: assert property ( // [RULE9]
    (st_q == twesp_pkg::ST_PROG && !prog_done) |=> st_q == twesp_pkg::ST_PROG && !oe_q)
    else $error("bus answered during programming");
  a_oe_after_fall: assert property ( // [RULE24]
    $rose(oe_q) |-> $past(ev.scl_fall))
    else $error("sda driven low outside an scl fall");
  a_dev_ack_match: assert property ( // [RULE1] [RULE2] [RULE5]
    (st_q == twesp_pkg::ST_ACK && ph_q == twesp_pkg::PH_DEV) |->
      (shift_q[7:4] == twesp_pkg::DEV_SEL) && (shift_q[3:1] == strap) && oe_q)
    else $error("device address acknowledged without a match");
  a_ack_ninth: assert property ( // [RULE22]
    (st_q == twesp_pkg::ST_RX && byte_done && !ev.start && !ev.stop &&
      (ph_q != twesp_pkg::PH_DEV || dev_match)) |=> oe_q && st_q == twesp_pkg::ST_ACK)
    else $error("received byte not acknowledged");

  a_prog_hold: assert property ( // [RULE23]
    $rose(st_q == twesp_pkg::ST_PROG) |-> (st_q == twesp_pkg::ST_PROG)[*8])
    else $error("programming cycle ended early");
  a_prog_bound: assert property ( // [RULE23] [RULE13]
    (st_q == twesp_pkg::ST_PROG) |-> prog_q <= PROG_LAST)
    else $error("programming cycle overran its time");
  a_page_row: assert property ( // [RULE11]
    pg_wr |=> addr_q[ADDR_W-1:PW] == $past(addr_q[ADDR_W-1:PW]) &&
      addr_q[PW-1:0] == PW'($past(addr_q[PW-1:0]) + 1'b1))
    else $error("page write address left its page");

  a_guard_block: assert property ( // [RULE6]
    (pg_wr && wr_prot && !pg_clr) |=> !mask_q[$past(addr_q[PW-1:0])])
    else $error("protected byte armed for programming");
  a_read_advance: assert property ( // [RULE15] [RULE18]
    tx_load |=> addr_q == ADDR_W'($past(addr_q) + 1'b1) && st_q == twesp_pkg::ST_TX)
    else $error("read address not advanced by one");

  a_start_dev: assert property ( // [RULE21]
    (ev.start && !ev.stop && st_q != twesp_pkg::ST_PROG) |=>
      st_q == twesp_pkg::ST_RX && ph_q == twesp_pkg::PH_DEV && cnt_q == 4'h0)
    else $error("start did not open a device address");

  a_stop_launch: assert property ( // [RULE8]
    (ev.stop && st_q != twesp_pkg::ST_PROG && !rw_q && pg_any_q) |=>
      st_q == twesp_pkg::ST_PROG && !oe_q)
    else $error("write stop did not launch programming");

endmodule : twesp_top

// [tb/twesp_host_model.sv]
/*
 * bus master model for the two-wire eeprom slave: start, stop, byte out, byte in
 * assumes the bench forms the wired-and data line with a pull-up and feeds it back
 */
`timescale 1ns/100ps

module twesp_host_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  // a quarter of the 160 ns bus clock, in system clocks
  localparam int Q = 8;

  // bus clock stands high between frames
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_i);
  endtask : wait_clk

  // also serves as repeated start, entered with the clock low
  task automatic start_cond();
    wait_clk(Q); sda_oe_o = 1'b0; wait_clk(Q); scl_o = 1'b1;
    wait_clk(Q); sda_oe_o = 1'b1; wait_clk(Q); scl_o = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    wait_clk(Q); sda_oe_o = 1'b1; wait_clk(Q); scl_o = 1'b1;
    wait_clk(Q); sda_oe_o = 1'b0; wait_clk(Q);
  endtask : stop_cond

  // data moves only while the clock is low; sampled mid-high
  task automatic clk_bit(input logic b, output logic got);
    wait_clk(Q); sda_oe_o = ~b; wait_clk(Q); scl_o = 1'b1;
    wait_clk(Q); got = sda_i; wait_clk(Q); scl_o = 1'b0;
  endtask : clk_bit

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], g);
    clk_bit(1'b1, g);
    ack = ~g;
  endtask : send_byte

  // more low leaves the acknowledge bit high to end a read
  task automatic recv_byte(input logic more, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, g);
      d[i] = g;
    end
    clk_bit(~more, g);
  endtask : recv_byte
endmodule : twesp_host_model

// [tb/twesp_top_tb.sv]
/*
 * self-checking bench for the two-wire eeprom slave
 * assumes a short programming time parameter and the host model file
 */
`timescale 1ns/100ps

module twesp_top_tb;
  localparam int unsigned PROG = 64;
  logic clk, rst_n, scl, sda_o, sda_oe, guard, host_oe;
  logic [2:0] strap;
  int bad_count = 0;
  int check_count = 0;
  // open drain line with pull-up
  wire sda = (sda_oe ? sda_o : 1'b1) & ~host_oe;

  twesp_top #(.PROG_CYCLES(PROG)) i_twesp_top (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE_O(sda_oe), .CHIP_SELECT_STRAP_MSB_I(strap[2]),
    .CHIP_SELECT_STRAP_MID_I(strap[1]), .CHIP_SELECT_STRAP_LSB_I(strap[0]),
    .WRITE_GUARD_I(guard));

  twesp_host_model i_twesp_host_model (
    .clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ******************************************************************
  // checking and closing
  // ******************************************************************
  task automatic chk_ack(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask : chk_ack

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk_byte

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done

  // ******************************************************************
  // transfers
  // ******************************************************************
  // retries the address while the part is busy programming
  task automatic poll(input logic rw, output int tries);
    logic ack;
    tries = 0;
    do begin
      if (tries > 0) i_twesp_host_model.stop_cond();
      i_twesp_host_model.start_cond();
      i_twesp_host_model.send_byte({twesp_pkg::DEV_SEL, strap, rw}, ack);
      tries++;
    end while (ack !== 1'b1 && tries < 50);
    chk_ack(ack, 1'b1, "poll");
  endtask : poll

  task automatic tx(input logic [7:0] b);
    logic ack;
    i_twesp_host_model.send_byte(b, ack);
    chk_ack(ack, 1'b1, "byte ack");
  endtask : tx

  task automatic wr(input logic [15:0] a, input logic [7:0] d[$]);
    int tries;
    poll(1'b0, tries);
    tx(a[15:8]);
    tx(a[7:0]);
    foreach (d[i]) tx(d[i]);
    i_twesp_host_model.stop_cond();
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] exp[$]);
    int tries;
    logic ack;
    logic [7:0] got;
    poll(1'b0, tries);
    tx(a[15:8]);
    tx(a[7:0]);
    i_twesp_host_model.start_cond();
    i_twesp_host_model.send_byte({twesp_pkg::DEV_SEL, strap, 1'b1}, ack);
    chk_ack(ack, 1'b1, "read address");
    foreach (exp[i]) begin
      i_twesp_host_model.recv_byte(i < exp.size() - 1, got);
      chk_byte(got, exp[i], "read data");
    end
    i_twesp_host_model.stop_cond();
  endtask : rd

  // ******************************************************************
  // scenarios
  // ******************************************************************
  // per strap value: match, one strap bit off, wrong selector
  task automatic t_straps();
    logic ack;
    for (int s = 0; s < 8; s++) begin
      strap = s[2:0];
      for (int m = 0; m < 3; m++) begin
        i_twesp_host_model.start_cond();
        i_twesp_host_model.send_byte({(m == 2) ? 4'hB : twesp_pkg::DEV_SEL,
          s[2:0] ^ {2'h0, m == 1}, 1'b0}, ack);
        chk_ack(ack, m == 0, "device select");
        i_twesp_host_model.stop_cond();
      end
    end
  endtask : t_straps

  task automatic t_byte();
    int tries;
    wr(16'h0123, '{8'h5A});
    poll(1'b0, tries);
    chk_byte(8'(tries), 8'h02, "poll count");
    i_twesp_host_model.stop_cond();
    rd(16'h0123, '{8'h5A});
  endtask : t_byte

  // 34 bytes from page offset 30: wrap and overwrite of the first two
  task automatic t_page();
    logic [7:0] d[$];
    logic [7:0] e[$];
    logic [7:0] got;
    int tries;
    for (int k = 0; k < 34; k++) d.push_back(8'h40 + k[7:0]);
    for (int j = 0; j < 32; j++) e.push_back(8'h42 + j[7:0]);
    wr(16'h0A5E, d);
    poll(1'b1, tries);
    i_twesp_host_model.recv_byte(1'b0, got);
    chk_byte(got, 8'h42, "current address");
    i_twesp_host_model.stop_cond();
    rd(16'h0A40, e);
  endtask : t_page

  task automatic t_wrap_guard();
    wr(16'hFFFF, '{8'h3C});
    wr(16'hE000, '{8'hC3});
    rd(16'h1FFF, '{8'h3C, 8'hC3});
    guard = 1'b1;
    wr(16'h1FFF, '{8'h11});
    wr(16'h17FF, '{8'h77});
    guard = 1'b0;
    rd(16'h1FFF, '{8'h3C});
    rd(16'h17FF, '{8'h77});
  endtask : t_wrap_guard

  initial begin
    rst_n = 1'b0;
    guard = 1'b0;
    strap = 3'h0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    chk_ack(sda_oe, 1'b0, "idle release");
    chk_ack(sda_o, 1'b0, "drive level");
    t_straps();
    t_byte();
    t_page();
    t_wrap_guard();
    test_done();
  end

  // about twice the expected run
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    $display("unexpected at %0t: run did not finish", $time);
    test_done();
  end
endmodule : twesp_top_tb
